// ---- hdl/ors_outage_restart.sv ----
// outage restart sequencer: outage recognition, restart pending, command window,
// restart wait and the restart itself; also times the line/drive switchover
// assumes all inputs synchronous to clk; settings held stable while in use
`timescale 1ns/10ps

module ors_outage_restart
    import ors_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              running,
    input  wire logic              underVoltage,
    input  wire logic              busBelowContLevel,
    input  wire logic [VOLT_W-1:0] busVoltage,
    input  wire logic              supply460,
    input  wire logic              chargeDone,
    input  wire logic              interlockInput,
    input  wire logic [2:0]        restartModeSelect,
    input  wire logic [1:0]        runCommandSource,
    input  wire logic [CNT_W-1:0]  allowableOutageTime,
    input  wire logic [CNT_W-1:0]  restartWaitTime,
    input  wire logic              useDefaultWait,
    input  wire logic [2:0]        capacityClass,
    input  wire logic              keypadRun,
    input  wire logic              forwardRunCommand,
    input  wire logic              reverseRunCommand,
    input  wire logic              coastStopCommand,
    input  wire logic              alarmReset,
    input  wire logic              instantOvercurrentLimitEnable,
    input  wire logic              freqMatched,
    input  wire logic [FREQ_W-1:0] outputFrequency,
    input  wire logic [FREQ_W-1:0] startingFrequencySetting,
    input  wire logic              lineSwitchRequest,
    output logic                   outputShutdown,
    output logic                   undervoltageAlarm,
    output logic                   continuousRunControl,
    output logic                   restartPending,
    output logic                   restartStart,
    output logic                   restartActive,
    output logic                   restartReverse,
    output logic [FREQ_W-1:0]      restartFrequency,
    output logic                   restartCancelled,
    output logic                   lineSwitchGo
);

    // =====================================================
    // tick
    logic tick;

    ors_tick_gen #(
        .TICK_CYCLES_P (TICK_CYCLES_P)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // =====================================================
    // derived conditions
    logic            outageSeen;
    logic            runCmd;
    logic            fixedDir;
    logic            modeRestarts;
    logic            untilFloor;
    logic [9:0]      allowTicks;
    logic [9:0]      waitTicks;
    logic [9:0]      floorVolt;
    logic            expired;
    logic            waitDone;

    // contactor opening drops the interlock, which stands for an outage too
    assign outageSeen   = running && (underVoltage || !interlockInput); // RULE1
    assign fixedDir     = (runCommandSource == SRC_FIXED_FWD) || (runCommandSource == SRC_FIXED_REV); // RULE5
    // source 0: keypad run still needed even with terminal direction
    assign runCmd       = (runCommandSource == SRC_KEYPAD_TERM) ? keypadRun && (forwardRunCommand || reverseRunCommand)
                          : (forwardRunCommand || reverseRunCommand); // RULE6
    assign modeRestarts = (restartModeSelect == MODE_CONT_RUN) || (restartModeSelect == MODE_SAVED_FREQ)
                          || (restartModeSelect == MODE_START_FREQ); // RULE16
    assign untilFloor   = (allowableOutageTime == OUTAGE_FLOOR); // RULE11
    // out of range settings clamp to the 30 s ceiling
    assign allowTicks   = (allowableOutageTime > OUTAGE_MAX) ? OUTAGE_MAX : allowableOutageTime; // RULE10
    assign waitTicks    = useDefaultWait ? ors_default_wait(capacityClass) : restartWaitTime; // RULE14
    assign floorVolt    = supply460 ? FLOOR_460_V : FLOOR_208_V; // RULE12

    // =====================================================
    // sequencer state and timers
    ors_state_t       state;
    ors_state_t       next_state;
    logic [9:0]       outageTicks;
    logic [9:0]       next_outageTicks;
    logic [9:0]       windowTicks;
    logic [9:0]       next_windowTicks;
    logic             floorHit;
    logic             next_floorHit;
    logic [FREQ_W-1:0] savedFrequency;
    logic [FREQ_W-1:0] next_savedFrequency;
    logic [2:0]       modeLatched;
    logic [2:0]       next_modeLatched;
    logic             next_outputShutdown;
    logic             next_undervoltageAlarm;
    logic             next_continuousRunControl;
    logic             next_restartPending;
    logic             next_restartStart;
    logic             next_restartActive;
    logic             next_restartReverse;
    logic [FREQ_W-1:0] next_restartFrequency;
    logic             next_restartCancelled;

    assign expired  = untilFloor ? floorHit : (outageTicks >= allowTicks); // RULE10 RULE11
    assign waitDone = (outageTicks >= waitTicks); // RULE13

    always_comb begin
        next_state                = state;
        next_outageTicks          = ors_count(outageTicks, tick); // RULE22
        next_windowTicks          = windowTicks;
        next_floorHit             = floorHit || (untilFloor && busVoltage < floorVolt); // RULE11
        next_savedFrequency       = savedFrequency;
        next_modeLatched          = modeLatched;
        next_outputShutdown       = outputShutdown;
        next_undervoltageAlarm    = undervoltageAlarm;
        next_continuousRunControl = 1'b0;
        next_restartStart         = 1'b0;
        next_restartActive        = 1'b0;
        next_restartReverse       = restartReverse;
        next_restartFrequency     = restartFrequency;
        next_restartCancelled     = 1'b0;
        case (state)
            ST_NORMAL: begin
                next_outageTicks = CNT_RESET;
                next_floorHit    = 1'b0;
                next_outputShutdown = 1'b0;
                // mode 3 rides through on stored inertia until undervoltage
                next_continuousRunControl = running && restartModeSelect == MODE_CONT_RUN
                                            && busBelowContLevel && !underVoltage; // RULE20
                if (outageSeen) begin
                    next_modeLatched    = restartModeSelect;
                    next_outputShutdown = 1'b1;
                    next_continuousRunControl = 1'b0;
                    if (modeRestarts) begin
                        next_state          = ST_PENDING; // RULE2
                        next_savedFrequency = outputFrequency; // RULE20
                        next_restartReverse = reverseRunCommand && !forwardRunCommand;
                    end else begin
                        next_state             = ST_TRIP;
                        next_undervoltageAlarm = (restartModeSelect == MODE_TRIP_ALARM); // RULE19
                    end
                end
            end
            ST_PENDING, ST_CHARGING, ST_WAIT_CMD: begin
                if (coastStopCommand) begin
                    next_state = ST_NORMAL; // RULE8
                    next_restartCancelled = 1'b1;
                end else if (expired) begin
                    next_state = ST_NORMAL; // RULE7 RULE10
                    next_restartCancelled = 1'b1;
                end else if (state == ST_PENDING) begin
                    if (!underVoltage)
                        next_state = ST_CHARGING; // RULE2
                end else if (state == ST_CHARGING) begin
                    if (chargeDone) begin
                        next_state       = ST_WAIT_CMD; // RULE3
                        next_windowTicks = CNT_RESET;
                    end
                end else begin
                    next_windowTicks = ors_count(windowTicks, tick);
                    if (fixedDir || runCmd) begin
                        next_state = ST_HOLDOFF; // RULE3 RULE5
                        if (fixedDir)
                            next_restartReverse = (runCommandSource == SRC_FIXED_REV); // RULE5
                        else
                            next_restartReverse = reverseRunCommand && !forwardRunCommand;
                    end else if (windowTicks >= WINDOW_TICKS) begin
                        next_state = ST_NORMAL; // RULE4
                        next_restartCancelled = 1'b1;
                    end
                end
            end
            ST_HOLDOFF: begin
                if (coastStopCommand) begin
                    next_state = ST_NORMAL; // RULE8
                    next_restartCancelled = 1'b1;
                end else if (waitDone) begin
                    next_state          = ST_RESTART; // RULE13
                    next_restartStart   = 1'b1;
                    next_restartActive  = 1'b1;
                    next_outputShutdown = 1'b0;
                    // without the fast limiter the speed search cannot work
                    if (modeLatched == MODE_START_FREQ || instantOvercurrentLimitEnable != OCL_ENABLED)
                        next_restartFrequency = startingFrequencySetting; // RULE21
                    else
                        next_restartFrequency = savedFrequency; // RULE9
                end
            end
            ST_RESTART: begin
                next_restartActive = 1'b1;
                // limiter pulls frequency down; done once it meets the motor
                if (freqMatched || restartFrequency == startingFrequencySetting) begin
                    next_state         = ST_NORMAL; // RULE9
                    next_restartActive = 1'b0;
                end
            end
            ST_TRIP: begin
                next_outputShutdown = 1'b1; // RULE19
                if (alarmReset || coastStopCommand) begin
                    next_state             = ST_NORMAL;
                    next_undervoltageAlarm = 1'b0;
                    next_outputShutdown    = 1'b0;
                end
            end
            default: next_state = ST_NORMAL;
        endcase
        next_restartPending = (next_state == ST_PENDING) || (next_state == ST_CHARGING)
                              || (next_state == ST_WAIT_CMD) || (next_state == ST_HOLDOFF); // RULE2
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= ST_NORMAL;
            outageTicks          <= CNT_RESET;
            windowTicks          <= CNT_RESET;
            floorHit             <= 1'b0;
            savedFrequency       <= FREQ_RESET;
            modeLatched          <= MODE_TRIP_ALARM;
            outputShutdown       <= 1'b0;
            undervoltageAlarm    <= 1'b0;
            continuousRunControl <= 1'b0;
            restartPending       <= 1'b0;
            restartStart         <= 1'b0;
            restartActive        <= 1'b0;
            restartReverse       <= 1'b0;
            restartFrequency     <= FREQ_RESET;
            restartCancelled     <= 1'b0;
        end else begin
            state                <= next_state;
            outageTicks          <= next_outageTicks;
            windowTicks          <= next_windowTicks;
            floorHit             <= next_floorHit;
            savedFrequency       <= next_savedFrequency;
            modeLatched          <= next_modeLatched;
            outputShutdown       <= next_outputShutdown;
            undervoltageAlarm    <= next_undervoltageAlarm;
            continuousRunControl <= next_continuousRunControl;
            restartPending       <= next_restartPending;
            restartStart         <= next_restartStart;
            restartActive        <= next_restartActive;
            restartReverse       <= next_restartReverse;
            restartFrequency     <= next_restartFrequency;
            restartCancelled     <= next_restartCancelled;
        end
    end

    // =====================================================
    // line/drive switchover wait
    logic       switchBusy;
    logic       next_switchBusy;
    logic [9:0] switchTicks;
    logic [9:0] next_switchTicks;
    logic       next_lineSwitchGo;

    always_comb begin
        next_switchBusy   = switchBusy;
        next_switchTicks  = switchTicks;
        next_lineSwitchGo = 1'b0;
        if (lineSwitchRequest && !switchBusy) begin
            next_switchBusy  = 1'b1;
            next_switchTicks = CNT_RESET;
        end else if (switchBusy) begin
            next_switchTicks = ors_count(switchTicks, tick);
            if (switchTicks >= waitTicks) begin
                next_switchBusy   = 1'b0; // RULE15
                next_lineSwitchGo = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switchBusy   <= 1'b0;
            switchTicks  <= CNT_RESET;
            lineSwitchGo <= 1'b0;
        end else begin
            switchBusy   <= next_switchBusy;
            switchTicks  <= next_switchTicks;
            lineSwitchGo <= next_lineSwitchGo;
        end
    end

endmodule // ors_outage_restart

// ---- hdl/ors_pkg.sv ----
// constants, codes and state type for the outage restart sequencer
// assumes a 10 MHz controller clock; durations are counted in 0.1 s timer ticks
//
// Function
// RULE1: outage recognised on undervoltage while running
// RULE2: outage enters pending; recovery passes charging first
// RULE3: ready-to-run opens two second command window
// RULE4: window expiry cancels pending; ordinary start later
// RULE5: fixed direction sources restart without command
// RULE6: keypad run, terminal direction still needs command
// RULE7: allowable outage elapsed cancels command wait early
// RULE8: coast stop during outage returns to normal
// RULE9: restart at saved frequency, limiter matches speed
// RULE10: allowable outage 0.0 to 30.0 seconds
// RULE11: setting 999 restarts until bus floor
// RULE12: floor 50 V (208 V), 100 V (460 V)
// RULE13: no restart before waiting time since outage
// RULE14: default waiting time follows drive capacity class
// RULE15: waiting time also gates line/drive switchover
// RULE16: modes 3, 4, 5 restart automatically
// RULE17: external run command within two seconds
// RULE18: interlock wired to contactor auxiliary contact
// RULE19: mode 0 trips with alarm, mode 1 without
// RULE20: mode 3 continuous running, saves frequency at undervoltage
// RULE21: mode 5 restarts from starting frequency
// RULE22: durations counted on 0.1 s timer tick

package ors_pkg;

    // =====================================================
    // timing
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          TICK_TIME_MS   = 100;
    localparam int          TICK_CYCLES    = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          WINDOW_TIME_MS = 2000;
    localparam int          CNT_W          = 10;
    localparam logic [9:0]  WINDOW_TICKS   = 10'(WINDOW_TIME_MS / TICK_TIME_MS);
    localparam logic [9:0]  OUTAGE_MAX     = 10'h12c;
    localparam logic [9:0]  OUTAGE_FLOOR   = 10'h3e7;
    localparam logic [9:0]  CNT_MAX        = 10'h3ff;

    // =====================================================
    // restart wait defaults per capacity class, in ms
    localparam int          WAIT_CLASS0_MS = 500;
    localparam int          WAIT_CLASS1_MS = 1000;
    localparam int          WAIT_CLASS2_MS = 1500;
    localparam int          WAIT_CLASS3_MS = 2000;
    localparam int          WAIT_CLASS4_MS = 2500;
    localparam int          WAIT_CLASS5_MS = 4000;
    localparam int          WAIT_CLASS6_MS = 5000;

    // =====================================================
    // bus voltage floors, volts
    localparam int          VOLT_W         = 10;
    localparam logic [9:0]  FLOOR_208_V    = 10'h032;
    localparam logic [9:0]  FLOOR_460_V    = 10'h064;

    // =====================================================
    // codes
    localparam int          FREQ_W          = 16;
    localparam logic [2:0]  MODE_TRIP_ALARM = 3'h0;
    localparam logic [2:0]  MODE_TRIP_QUIET = 3'h1;
    localparam logic [2:0]  MODE_CONT_RUN   = 3'h3;
    localparam logic [2:0]  MODE_SAVED_FREQ = 3'h4;
    localparam logic [2:0]  MODE_START_FREQ = 3'h5;
    localparam logic [1:0]  SRC_KEYPAD_TERM = 2'h0;
    localparam logic [1:0]  SRC_FIXED_FWD   = 2'h2;
    localparam logic [1:0]  SRC_FIXED_REV   = 2'h3;
    localparam logic        OCL_ENABLED     = 1'h1;
    localparam logic [15:0] FREQ_RESET      = 16'h0000;
    localparam logic [9:0]  CNT_RESET       = 10'h000;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_PENDING,
        ST_CHARGING,
        ST_WAIT_CMD,
        ST_HOLDOFF,
        ST_RESTART,
        ST_TRIP
    } ors_state_t;

    // capacity class to default waiting time in ticks
    function automatic logic [9:0] ors_default_wait(input logic [2:0] capClass);
        int ms;
        case (capClass)
            3'h0:    ms = WAIT_CLASS0_MS;
            3'h1:    ms = WAIT_CLASS1_MS;
            3'h2:    ms = WAIT_CLASS2_MS;
            3'h3:    ms = WAIT_CLASS3_MS;
            3'h4:    ms = WAIT_CLASS4_MS;
            3'h5:    ms = WAIT_CLASS5_MS;
            default: ms = WAIT_CLASS6_MS;
        endcase
        return 10'(ms / TICK_TIME_MS);
    endfunction

    // saturating tick counter step
    function automatic logic [9:0] ors_count(input logic [9:0] cnt, input logic tick);
        return (tick && cnt != CNT_MAX) ? 10'(cnt + 10'h001) : cnt;
    endfunction

endpackage

// ---- hdl/ors_tick_gen.sv ----
// timer tick generator: one-cycle pulse every tickCycles clocks
// assumes a free running clock; the division is a parameter so simulation can shorten it
`timescale 1ns/10ps

module ors_tick_gen
    import ors_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);

    localparam int DIV_W = $clog2(TICK_CYCLES_P + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES_P - 1);

    logic [DIV_W-1:0] divCnt;
    logic [DIV_W-1:0] next_divCnt;
    logic             next_tick;

    // =====================================================
    // divider
    always_comb begin
        next_tick   = 1'b0;
        next_divCnt = DIV_W'(divCnt + 1'b1);
        if (divCnt == DIV_LAST) begin
            next_divCnt = '0;
            next_tick   = 1'b1; // RULE22
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= '0;
            tick   <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            tick   <= next_tick;
        end
    end

endmodule // ors_tick_gen

// ---- tb/ors_run_circuit.sv ----
// partner model: external run relay and output contactor auxiliary contact
// assumes supplyOk low is a dead supply; relay picks up after a delay
`timescale 1ns/10ps

module ors_run_circuit #(
    parameter int DELAY = 15
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supplyOk,
    input  wire logic runWanted,
    output logic      forwardRunCommand,
    output logic      interlockInput
);
    // ============================================
    // relay pick-up delay, kept well inside the command window
    logic [7:0] pickUp;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pickUp <= 8'h00;
        else if (!supplyOk) pickUp <= 8'h00;
        else if (pickUp != 8'(DELAY)) pickUp <= pickUp + 8'h01;
    end
    assign forwardRunCommand = runWanted && pickUp == 8'(DELAY);
    assign interlockInput    = supplyOk;
endmodule // ors_run_circuit

// ---- tb/ors_outage_restart_monitor.sv ----
// checker for the outage restart sequencer, bound to its top module
// assumes settings are held stable while an outage is handled
`timescale 1ns/10ps

module ors_outage_restart_monitor
    import ors_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        running,
    input wire logic        underVoltage,
    input wire logic [2:0]  restartModeSelect,
    input wire logic [9:0]  restartWaitTime,
    input wire logic        useDefaultWait,
    input wire logic        coastStopCommand,
    input wire logic [15:0] startingFrequencySetting,
    input wire logic        outputShutdown,
    input wire logic        undervoltageAlarm,
    input wire logic        restartPending,
    input wire logic        restartStart,
    input wire logic        restartActive,
    input wire logic [15:0] restartFrequency,
    input wire logic        restartCancelled,
    input wire logic        lineSwitchGo
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ============================================
    // cycles spent pending; one tick of slack for the free-running tick phase
    logic [19:0] pendCycles;
    logic [19:0] next_pendCycles;
    always_comb next_pendCycles = restartPending ? pendCycles + 20'h00001 : 20'h00000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pendCycles <= 20'h00000;
        else pendCycles <= next_pendCycles;
    end
    wire idle = !outputShutdown && !restartPending && !restartActive;
    // ============================================
    // assertions
    a_outage_pending: assert property (running && underVoltage && idle
        && restartModeSelect inside {3'h3, 3'h4, 3'h5} |=> restartPending && outputShutdown)
        else $error("outage missed");
    a_trip_alarm: assert property (running && underVoltage && idle && restartModeSelect == MODE_TRIP_ALARM
        |=> undervoltageAlarm && outputShutdown) else $error("no alarm");
    a_alarm_mode: assert property ($rose(undervoltageAlarm) |-> $past(restartModeSelect) == MODE_TRIP_ALARM)
        else $error("stray alarm");
    a_start_state: assert property (restartStart |-> restartActive && !restartPending && !outputShutdown
        ##1 !restartStart) else $error("bad start");
    a_wait_held: assert property (restartStart && !useDefaultWait
        |-> int'(pendCycles) + TICK_CYCLES_P >= int'(restartWaitTime) * TICK_CYCLES_P) else $error("early start");
    a_coast_cancel: assert property (restartPending && coastStopCommand |=> !restartPending)
        else $error("coast ignored");
    a_cancel_clean: assert property (restartCancelled |-> !restartPending && !restartActive
        ##1 !restartCancelled) else $error("bad cancel");
    a_start_freq: assert property (restartActive && restartModeSelect == MODE_START_FREQ
        |-> restartFrequency == startingFrequencySetting) else $error("bad mode 5 freq");
    a_switch_pulse: assert property (lineSwitchGo |=> !lineSwitchGo) else $error("long switch go");
endmodule // ors_outage_restart_monitor

bind ors_outage_restart ors_outage_restart_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_mon (.*);

// ---- tb/ors_outage_restart_bench.sv ----
// self-checking bench for the outage restart sequencer with the run relay model
// assumes a 10 MHz clock and a timer tick shortened to ten clocks
`timescale 1ns/10ps

module ors_outage_restart_bench import ors_pkg::*;;
    localparam int T = 10;
    logic clk, rst_n, running, underVoltage, busBelowContLevel, supply460, chargeDone, interlockInput, keypadRun;
    logic forwardRunCommand, reverseRunCommand, coastStopCommand, alarmReset, instantOvercurrentLimitEnable;
    logic freqMatched, lineSwitchRequest, useDefaultWait, supplyOk, runWanted, outputShutdown, undervoltageAlarm;
    logic continuousRunControl, restartPending, restartStart, restartActive, restartReverse, restartCancelled;
    logic lineSwitchGo;
    logic [2:0]  restartModeSelect, capacityClass;
    logic [1:0]  runCommandSource;
    logic [9:0]  allowableOutageTime, restartWaitTime, busVoltage;
    logic [15:0] outputFrequency, startingFrequencySetting, restartFrequency;
    typedef struct {logic cancel; logic reverse_run_command; logic [15:0] freq;} ors_exp_t;
    ors_exp_t expq[$];
    int err_count = 0, tests_run = 0, seed = 84, k, n;
    int dflt[7] = '{5, 10, 15, 20, 25, 40, 50};

    ors_outage_restart #(.TICK_CYCLES_P(T)) u_dut (.*);
    ors_run_circuit u_run (.clk, .rst_n, .supplyOk, .runWanted, .forwardRunCommand, .interlockInput);

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // ============================================
    // shared tasks
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one outage and recovery; kind 0 restart, 1 cancel, 2 trip, 3 coast stop
    task automatic outage(input logic [2:0] md, input logic [1:0] src, input logic cmd, input int down, input int kind);
        ors_exp_t e;
        int i;
        restartModeSelect = md;
        runCommandSource = src;
        runWanted = cmd;
        outputFrequency = 16'($random(seed));
        cyc(3);
        chk("cont", 16'(md == 3'h3), 16'(continuousRunControl));
        e.cancel = (kind == 1 || kind == 3);
        e.reverse_run_command = (src == 2'h3);
        e.freq = (md == 3'h5 || !instantOvercurrentLimitEnable) ? startingFrequencySetting : outputFrequency;
        if (kind != 2) expq.push_back(e);
        supplyOk = 0;
        underVoltage = 1;
        cyc(2);
        running = 0;
        coastStopCommand = (kind == 3);
        cyc(down);
        coastStopCommand = 0;
        supplyOk = 1;
        underVoltage = 0;
        cyc(5);
        chargeDone = 1;
        for (i = 0; i < 400 && expq.size() > 0; i++) cyc(1);
        chk("left", 16'h0, 16'(expq.size()));
        expq.delete();
        chk("alarm", 16'(md == 3'h0), 16'(undervoltageAlarm));
        chk("shut", 16'(md < 3'h3), 16'(outputShutdown));
        chargeDone = 0;
        alarmReset = 1;
        running = 1;
        cyc(1);
        alarmReset = 0;
        cyc(20);
    endtask
    // ============================================
    // watcher: outputs are settled at the falling edge
    always @(negedge clk) begin
        ors_exp_t e;
        if (restartStart || restartCancelled) begin
            e = (expq.size() > 0) ? expq.pop_front() : '{1'bx, 1'bx, 16'hxxxx};
            chk("cancel", 16'(e.cancel), 16'(restartCancelled));
            if (restartStart) chk("freq", e.freq, restartFrequency);
            if (restartStart) chk("dir", 16'(e.reverse_run_command), 16'(restartReverse));
        end
    end
    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
    // ============================================
    // main sequence
    initial begin
        {rst_n, underVoltage, supply460, chargeDone, keypadRun, reverseRunCommand, coastStopCommand, alarmReset,
         lineSwitchRequest, useDefaultWait, restartModeSelect, capacityClass, runCommandSource, outputFrequency} = '0;
        {running, busBelowContLevel, freqMatched, instantOvercurrentLimitEnable, supplyOk, runWanted} = 6'h3f;
        allowableOutageTime = 10'h12c;
        restartWaitTime = 10'h008;
        busVoltage = 10'h12c;
        startingFrequencySetting = 16'h0123;
        cyc(20);
        rst_n = 1;
        cyc(30);
        outage(3'h4, 2'h1, 1'h1, 20, 0);
        outage(3'h3, 2'h1, 1'h1, 20, 0);
        outage(3'h5, 2'h1, 1'h1, 20, 0);
        outage(3'h4, 2'h2, 1'h0, 20, 0);
        outage(3'h4, 2'h3, 1'h0, 20, 0);
        outage(3'h4, 2'h0, 1'h0, 20, 1);
        allowableOutageTime = 10'h006;
        outage(3'h4, 2'h1, 1'h0, 3, 1);
        allowableOutageTime = 10'h12c;
        outage(3'h4, 2'h1, 1'h1, 20, 3);
        outage(3'h0, 2'h1, 1'h1, 20, 2);
        outage(3'h1, 2'h1, 1'h1, 20, 2);
        instantOvercurrentLimitEnable = 0;
        outage(3'h4, 2'h1, 1'h1, 20, 0);
        instantOvercurrentLimitEnable = 1;
        allowableOutageTime = 10'h3e7;
        for (k = 0; k < 4; k++) begin
            supply460 = k[1];
            busVoltage = (k[1] ? 10'h064 : 10'h032) - 10'(!k[0]);
            outage(3'h4, 2'h1, 1'h1, 20, k[0] ? 0 : 1);
        end
        busVoltage = 10'h12c;
        useDefaultWait = 1;
        for (k = 0; k < 7; k++) begin
            capacityClass = 3'(k);
            lineSwitchRequest = 1;
            cyc(1);
            lineSwitchRequest = 0;
            for (n = 0; n < 700 && lineSwitchGo !== 1'b1; n++) cyc(1);
            chk("switch", 16'h1, 16'(n >= (dflt[k] - 1) * T && n <= (dflt[k] + 2) * T));
            cyc(5);
        end
        stop_test();
    end
endmodule // ors_outage_restart_bench
